// File: uac_pkg.sv
// constants shared by the serial port control block and its receiver warm-up timer
// assumes a 100 MHz base clock and an AHB-Lite register bus with 32-bit data
package uac_pkg;

	// register byte offsets
	localparam logic [7:0] UAC_CTRL_OFF   = 8'h00;
	localparam logic [7:0] UAC_OPT_OFF    = 8'h04;
	localparam logic [7:0] UAC_STATUS_OFF = 8'h08;

	// control register fields
	localparam int UAC_PWR_BIT   = 7;
	localparam int UAC_TXE_BIT   = 6;
	localparam int UAC_RXE_BIT   = 5;
	localparam int UAC_ORDER_BIT = 4;
	localparam int UAC_PAR_HI    = 3;
	localparam int UAC_PAR_LO    = 2;
	localparam int UAC_CLEN_BIT  = 1;
	localparam int UAC_STOP_BIT  = 0;
	localparam logic [7:0] UAC_CTRL_RESET = 8'h10;

	// option register: transmit level inversion
	localparam int UAC_INV_BIT = 0;
	localparam logic UAC_INV_RESET = 1'b0;

	// status register fields
	localparam int UAC_ST_ACCEPT_BIT = 0;
	localparam int UAC_ST_EDGE_BIT   = 1;
	localparam int UAC_ST_PWR_BIT    = 2;

	// parity modes
	typedef enum logic [1:0] {
		UAC_PAR_NONE = 2'b00,
		UAC_PAR_ZERO = 2'b01,
		UAC_PAR_ODD  = 2'b10,
		UAC_PAR_EVEN = 2'b11
	} uac_parity_t;

	// receiver warm-up, in base clock cycles
	localparam int UAC_CNT_W = 3;
	localparam logic [UAC_CNT_W-1:0] UAC_RX_ACCEPT_CYC = 3'h2;
	localparam logic [UAC_CNT_W-1:0] UAC_RX_EDGE_CYC   = 3'h4;

	// bus encodings
	localparam logic [1:0] UAC_HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] UAC_HTRANS_SEQ    = 2'b11;
	localparam logic       UAC_HRESP_OKAY    = 1'b0;

endpackage

// File: uac_rx_warmup.sv
// receiver warm-up timer: delays data acceptance and rising-edge detection
// assumes rst is the port reset (system reset or power off), asynchronous
`timescale 1ns/1ns
module uac_rx_warmup
	import uac_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic enable,
	output logic      accept_q,
	output logic      edge_q
);

	logic [UAC_CNT_W-1:0] cnt_q;
	logic [UAC_CNT_W-1:0] cnt_d;
	logic                 accept_d;
	logic                 edge_d;

	// saturates at the longest delay so it never wraps
	assign cnt_d = !enable ? '0 :
		(cnt_q == UAC_RX_EDGE_CYC) ? cnt_q : cnt_q + 3'h1;
	assign accept_d = enable && (cnt_q >= UAC_RX_ACCEPT_CYC - 3'h1);
	assign edge_d   = enable && (cnt_q >= UAC_RX_EDGE_CYC - 3'h1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q    <= '0;
			accept_q <= 1'b0;
			edge_q   <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			accept_q <= accept_d;
			edge_q   <= edge_d;
		end
	end

	property p_accept_late;
		@(posedge clk) disable iff (rst)
		$rose(enable) |-> !accept_q ##1 !accept_q;
	endproperty
	a_accept_late: assert property (p_accept_late) else $error("accept came too early");

	property p_accept_on;
		@(posedge clk) disable iff (rst)
		$rose(enable) ##1 enable ##1 enable |-> accept_q;
	endproperty
	a_accept_on: assert property (p_accept_on) else $error("accept missing after two cycles");

	sequence s_edge_wait;
		$rose(enable) ##1 enable[*4];
	endsequence

	property p_edge_on;
		@(posedge clk) disable iff (rst)
		s_edge_wait |-> edge_q;
	endproperty
	a_edge_on: assert property (p_edge_on) else $error("edge detect missing after four cycles");

	property p_edge_late;
		@(posedge clk) disable iff (rst)
		$rose(enable) |-> (!edge_q)[*4];
	endproperty
	a_edge_late: assert property (p_edge_late) else $error("edge detect came too early");

endmodule

// File: uac_ctrl.sv
// control register and enable logic of the asynchronous serial port
// assumes one AHB-Lite master, zero-wait slave; serial shifters sit outside
//
// Functional notes
// - control register is 8 bits, read and written as byte or bit
// - reset loads 10h: port off, tx and rx off, lsb first
// - bit 7 powers the port; clearing it resets port logic asynchronously
// - while powered off tx pin idles high, or low when inverted
// - bit 6 enables transmitter; power set first, cleared last
// - bit 5 enables receiver; power set first, cleared last
// - receiver accepts data two cycles after its enable is set; rx_accept_en here rises three cycles after bit 5 is set
// - rx rising-edge detection starts four cycles after enable is set; rx_edge_en here rises five cycles after bit 5 is set
// - bit 1 selects 7 or 8 data bits; lin needs 8
// - bit 0 selects one or two transmitted stop bits
// - zero parity reception performs no parity check
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module uac_ctrl
	import uac_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// from the transmit shifter
	input  wire logic        tx_serial_data,
	// to the port logic
	output logic             serial_tx_pin,
	output logic             port_reset,
	output logic             tx_enable,
	output logic             rx_enable,
	output logic             rx_accept_en,
	output logic             rx_edge_en,
	output logic             bit_order_lsb,
	output logic      [1:0]  parity_mode,
	output logic             parity_check_en,
	output logic             char_len_eight,
	output logic             stop_two
);

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		reg_hit = (addr[7:2] == off[7:2]);
	endfunction

	// register state
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic       inv_q;
	logic       inv_d;

	// data phase bookkeeping
	logic       wr_pend_q;
	logic [7:0] wr_addr_q;
	logic       wr_lane0_q;

	logic        addr_valid;
	logic        rd_req;
	logic        wr_req;
	logic        wr_ctrl;
	logic        wr_opt;
	logic        order_locked;
	logic [7:0]  ctrl_wr_val;
	logic [31:0] rd_val;
	logic        pwr_d;
	logic        port_rst;
	logic        rx_en_gated;
	logic        accept_w;
	logic        edge_w;
	logic        par_check_d;

	assign addr_valid = hsel && hready && (htrans == UAC_HTRANS_NONSEQ || htrans == UAC_HTRANS_SEQ);
	assign rd_req     = addr_valid && !hwrite;
	assign wr_req     = addr_valid && hwrite;

	// only byte lane 0 carries register data; other lanes are ignored
	assign wr_ctrl = wr_pend_q && wr_lane0_q && reg_hit(wr_addr_q, UAC_CTRL_OFF);
	assign wr_opt  = wr_pend_q && wr_lane0_q && reg_hit(wr_addr_q, UAC_OPT_OFF);

	// order must not change under a running frame
	assign order_locked = ctrl_q[UAC_PWR_BIT] && (ctrl_q[UAC_TXE_BIT] || ctrl_q[UAC_RXE_BIT]);
	assign ctrl_wr_val = {hwdata[7:5],
		order_locked ? ctrl_q[UAC_ORDER_BIT] : hwdata[UAC_ORDER_BIT],
		hwdata[3:0]};
	assign ctrl_d = wr_ctrl ? ctrl_wr_val : ctrl_q;
	assign inv_d  = wr_opt ? hwdata[UAC_INV_BIT] : inv_q;
	assign pwr_d  = ctrl_d[UAC_PWR_BIT];

	// read mux looks at next control and option values so a read of them right after a write is current
	assign rd_val =
		reg_hit(haddr[7:0], UAC_CTRL_OFF) ? {24'h0, ctrl_d} :
		reg_hit(haddr[7:0], UAC_OPT_OFF)  ? {31'h0, inv_d} :
		reg_hit(haddr[7:0], UAC_STATUS_OFF) ?
			{29'h0, ctrl_q[UAC_PWR_BIT], edge_w, accept_w} : 32'h0;

	// power off holds the rx warm-up timer in reset, no clock needed; the registered outputs drop on the same edge that clears bit 7
	assign port_rst = sys_rst || !ctrl_q[UAC_PWR_BIT];

	// enables act only with power on
	assign rx_en_gated = ctrl_q[UAC_RXE_BIT] && ctrl_q[UAC_PWR_BIT];

	// zero parity and no parity both skip the check
	assign par_check_d = pwr_d && ctrl_d[UAC_RXE_BIT] &&
		(ctrl_d[UAC_PAR_HI:UAC_PAR_LO] == UAC_PAR_ODD ||
		 ctrl_d[UAC_PAR_HI:UAC_PAR_LO] == UAC_PAR_EVEN);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend_q  <= 1'b0;
			wr_addr_q  <= 8'h00;
			wr_lane0_q <= 1'b0;
			hrdata     <= 32'h0;
			hreadyout  <= 1'b0;
		end else begin
			wr_pend_q  <= wr_req;
			wr_addr_q  <= haddr[7:0];
			wr_lane0_q <= (haddr[1:0] == 2'b00);
			hrdata     <= rd_req ? rd_val : 32'h0;
			hreadyout  <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= UAC_CTRL_RESET;
			inv_q  <= UAC_INV_RESET;
		end else begin
			ctrl_q <= ctrl_d;
			inv_q  <= inv_d;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_tx_pin   <= 1'b1;
			port_reset      <= 1'b1;
			tx_enable       <= 1'b0;
			rx_enable       <= 1'b0;
			bit_order_lsb   <= UAC_CTRL_RESET[UAC_ORDER_BIT];
			parity_mode     <= UAC_PAR_NONE;
			parity_check_en <= 1'b0;
			char_len_eight  <= 1'b0;
			stop_two        <= 1'b0;
		end else begin
			serial_tx_pin   <= pwr_d ? (tx_serial_data ^ inv_d) : !inv_d;
			port_reset      <= !pwr_d;
			tx_enable       <= pwr_d && ctrl_d[UAC_TXE_BIT];
			rx_enable       <= pwr_d && ctrl_d[UAC_RXE_BIT];
			bit_order_lsb   <= ctrl_d[UAC_ORDER_BIT];
			parity_mode     <= ctrl_d[UAC_PAR_HI:UAC_PAR_LO];
			parity_check_en <= par_check_d;
			char_len_eight  <= ctrl_d[UAC_CLEN_BIT];
			stop_two        <= ctrl_d[UAC_STOP_BIT];
		end
	end

	// zero-wait bus: hresp never leaves OKAY
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hresp <= UAC_HRESP_OKAY;
		end else begin
			hresp <= UAC_HRESP_OKAY;
		end
	end

	uac_rx_warmup u_rx_warmup (
		.clk      (clk),
		.rst      (port_rst),
		.enable   (rx_en_gated),
		.accept_q (accept_w),
		.edge_q   (edge_w)
	);

	// warm-up flags pass through one more flop to stay registered at the top
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_accept_en <= 1'b0;
			rx_edge_en   <= 1'b0;
		end else begin
			rx_accept_en <= accept_w && pwr_d;
			rx_edge_en   <= edge_w && pwr_d;
		end
	end

	property p_reset_value;
		@(posedge clk) disable iff (sys_rst)
		$fell(sys_rst) |-> (ctrl_q == UAC_CTRL_RESET) && !tx_enable && !rx_enable;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("bad control reset value");

	property p_ctrl_write;
		@(posedge clk) disable iff (sys_rst)
		wr_ctrl |=> ctrl_q[7:5] == $past(hwdata[7:5]) && ctrl_q[3:0] == $past(hwdata[3:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_power_off;
		@(posedge clk) disable iff (sys_rst)
		!ctrl_q[UAC_PWR_BIT] |-> port_reset && !tx_enable && !rx_enable && !rx_accept_en;
	endproperty
	a_power_off: assert property (p_power_off) else $error("port active while powered off");

	property p_tx_idle;
		@(posedge clk) disable iff (sys_rst)
		!ctrl_q[UAC_PWR_BIT] |-> serial_tx_pin == !inv_q;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("tx pin not at idle level");

	property p_tx_gate;
		@(posedge clk) disable iff (sys_rst)
		tx_enable == (ctrl_q[UAC_PWR_BIT] && ctrl_q[UAC_TXE_BIT]);
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("tx enable not gated by power");

	property p_rx_gate;
		@(posedge clk) disable iff (sys_rst)
		rx_enable == (ctrl_q[UAC_PWR_BIT] && ctrl_q[UAC_RXE_BIT]);
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("rx enable not gated by power");

	property p_order_hold;
		@(posedge clk) disable iff (sys_rst)
		order_locked |=> $stable(ctrl_q[UAC_ORDER_BIT]) && $stable(bit_order_lsb);
	endproperty
	a_order_hold: assert property (p_order_hold) else $error("bit order changed while busy");

	property p_zero_parity;
		@(posedge clk) disable iff (sys_rst)
		parity_mode inside {UAC_PAR_ZERO, UAC_PAR_NONE} |-> !parity_check_en;
	endproperty
	a_zero_parity: assert property (p_zero_parity) else $error("parity check with zero parity");

endmodule

// File: uac_line_partner.sv
// far-side line receiver: samples the transmit line once per base clock
// assumes the line is driven by the port at all times, powered or not
`timescale 1ns/1ns
module uac_line_partner (
	input  wire logic clk,
	input  wire logic serial_line,
	output logic      seen_bit
);
	// no oversampling: the bench only looks at steady levels
	always_ff @(posedge clk) begin
		seen_bit <= serial_line;
	end
endmodule

// File: testbench.sv
// self-checking bench for the serial port control block
// assumes a zero-wait slave; hready follows hreadyout, one master
`timescale 1ns/1ns
module testbench;
	import uac_pkg::*;
	logic        clk;
	logic        sys_rst;
	logic        hsel;
	logic        hwrite;
	logic        tx_serial_data;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0]  htrans;
	logic [1:0]  parity_mode;
	logic [2:0]  hsize;
	logic        hreadyout;
	logic        hresp;
	logic        serial_tx_pin;
	logic        port_reset;
	logic        tx_enable;
	logic        rx_enable;
	logic        rx_accept_en;
	logic        rx_edge_en;
	logic        bit_order_lsb;
	logic        parity_check_en;
	logic        char_len_eight;
	logic        stop_two;
	logic        seen_bit;
	logic [7:0]  v;
	int          n_errors;
	int          check_count;
	int          cyc;

	uac_ctrl dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tx_serial_data(tx_serial_data),
		.serial_tx_pin(serial_tx_pin), .port_reset(port_reset), .tx_enable(tx_enable),
		.rx_enable(rx_enable), .rx_accept_en(rx_accept_en), .rx_edge_en(rx_edge_en),
		.bit_order_lsb(bit_order_lsb), .parity_mode(parity_mode),
		.parity_check_en(parity_check_en), .char_len_eight(char_len_eight),
		.stop_two(stop_two));

	uac_line_partner line (.clk(clk), .serial_line(serial_tx_pin), .seen_bit(seen_bit));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard: the whole sequence needs a little over a hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one single transfer; read data kept in rd, ends 1 ns after the data edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		haddr  <= {24'h0, a};
		hwrite <= w;
		htrans <= UAC_HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check("hresp", 32'h0, {31'h0, hresp});
		#1;
	endtask

	task automatic edges(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	initial begin
		sys_rst = 1'b1;
		hsel = 1'b1;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		tx_serial_data = 1'b0;
		n_errors = 0;
		check_count = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		bus(UAC_CTRL_OFF, 1'b0, 32'h0);
		check("ctrl reset", 32'h10, rd);
		check("port reset", 32'h1, {31'h0, port_reset});
		check("idle line", 32'h1, {31'h0, seen_bit});
		bus(UAC_OPT_OFF, 1'b1, 32'h1);
		edges(2);
		check("inverted idle", 32'h0, {31'h0, seen_bit});
		bus(UAC_OPT_OFF, 1'b1, 32'h0);
		// upper data bits must not reach the 8-bit register
		bus(UAC_CTRL_OFF, 1'b1, 32'hffff_ff80);
		bus(UAC_CTRL_OFF, 1'b0, 32'h0);
		check("ctrl power", 32'h80, rd);
		check("port run", 32'h0, {31'h0, port_reset});
		@(posedge clk);
		tx_serial_data <= 1'b1;
		edges(3);
		check("line data", 32'h1, {31'h0, seen_bit});
		bus(UAC_CTRL_OFF, 1'b1, 32'hd0);
		bus(UAC_CTRL_OFF, 1'b1, 32'hc0);
		bus(UAC_CTRL_OFF, 1'b0, 32'h0);
		check("order kept busy", 32'hd0, rd);
		check("tx enable", 32'h1, {31'h0, tx_enable});
		check("lsb first", 32'h1, {31'h0, bit_order_lsb});
		bus(UAC_CTRL_OFF, 1'b1, 32'h80);
		bus(UAC_CTRL_OFF, 1'b1, 32'h80);
		check("msb first", 32'h0, {31'h0, bit_order_lsb});
		check("tx off", 32'h0, {31'h0, tx_enable});
		bus(UAC_CTRL_OFF, 1'b1, 32'ha0);
		edges(2);
		check("accept early", 32'h0, {31'h0, rx_accept_en});
		edges(1);
		check("accept on", 32'h1, {31'h0, rx_accept_en});
		edges(1);
		check("edge early", 32'h0, {31'h0, rx_edge_en});
		edges(1);
		check("edge on", 32'h1, {31'h0, rx_edge_en});
		check("rx enable", 32'h1, {31'h0, rx_enable});
		bus(UAC_STATUS_OFF, 1'b0, 32'h0);
		check("status", 32'h7, rd);
		for (int p = 0; p < 4; p++) begin
			v = 8'ha0 | 8'(p << 2) | 8'(p);
			bus(UAC_CTRL_OFF, 1'b1, {24'h0, v});
			check("parity", 32'(p), {30'h0, parity_mode});
			check("parity check", 32'(p >> 1), {31'h0, parity_check_en});
			check("length", 32'(p >> 1), {31'h0, char_len_eight});
			check("stop", 32'(p & 1), {31'h0, stop_two});
		end
		bus(UAC_CTRL_OFF, 1'b1, 32'h80);
		edges(1);
		check("rx off", 32'h0, {31'h0, rx_enable});
		// accept flag leaves through the warm-up flop and the output flop
		edges(1);
		check("accept drop", 32'h0, {31'h0, rx_accept_en});
		bus(UAC_CTRL_OFF, 1'b1, 32'ha0);
		edges(2);
		check("rx reinit early", 32'h0, {31'h0, rx_accept_en});
		edges(1);
		check("rx reinit", 32'h1, {31'h0, rx_accept_en});
		bus(UAC_CTRL_OFF, 1'b1, 32'h80);
		// lin setup: order changed only while tx and rx are off
		bus(UAC_CTRL_OFF, 1'b1, 32'h92);
		bus(UAC_CTRL_OFF, 1'b1, 32'hd2);
		check("lin order", 32'h1, {31'h0, bit_order_lsb});
		check("lin parity", 32'h0, {30'h0, parity_mode});
		check("lin length", 32'h1, {31'h0, char_len_eight});
		bus(UAC_CTRL_OFF, 1'b1, 32'h92);
		check("tx reinit off", 32'h0, {31'h0, tx_enable});
		edges(2);
		bus(UAC_CTRL_OFF, 1'b1, 32'hd2);
		check("tx reinit on", 32'h1, {31'h0, tx_enable});
		bus(UAC_CTRL_OFF, 1'b1, 32'h92);
		bus(UAC_CTRL_OFF, 1'b1, 32'h00);
		@(posedge clk);
		tx_serial_data <= 1'b0;
		edges(3);
		check("off idle", 32'h1, {31'h0, seen_bit});
		check("port reset off", 32'h1, {31'h0, port_reset});
		bus(8'h20, 1'b1, 32'hff);
		bus(8'h20, 1'b0, 32'h0);
		check("unmapped", 32'h0, rd);
		bus(UAC_STATUS_OFF, 1'b1, 32'hff);
		bus(UAC_STATUS_OFF, 1'b0, 32'h0);
		check("status off", 32'h0, rd);
		give_verdict();
	end
endmodule
